//--- src/bmc_pkg.sv
// package: constants and types for burst and restart mode control
package bmc_pkg;
  // ==========================================================
  // timebase
  localparam int CLK_HZ     = 10_000_000;
  localparam int T_SEL_US   = 2;
  localparam int T_BURST_MS = 20;
  localparam int T_OVL_MS   = 40;
  localparam int T_EXT_US   = 210;
  // least times round up
  localparam int SEL_CYC   = (T_SEL_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int BURST_CYC = T_BURST_MS * (CLK_HZ / 1000);
  localparam int OVL_CYC   = T_OVL_MS * (CLK_HZ / 1000);
  localparam int EXT_CYC   = (T_EXT_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int CNT_W     = 20;
  localparam int SEL_W     = 5;
  localparam int EXT_W     = 12;
  // ==========================================================
  // register map, byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_THRESH = 4'h8;
  localparam int CTRL_BURST_EN = 0;
  localparam int CTRL_LATCH_CLR = 1;
  localparam logic CTRL_BURST_EN_RST = 1'b1;
  localparam int ST_LEVEL = 0;
  localparam int ST_DET   = 2;
  localparam int ST_FLAG  = 3;
  localparam int ST_BIAS  = 4;
  localparam int ST_ODD   = 5;
  localparam int ST_MODE  = 8;
  localparam int TH_LIMIT = 16;
  // ==========================================================
  // thresholds in millivolts
  localparam logic [11:0] ENTRY_L1_MV = 12'h050a; // 1290
  localparam logic [11:0] ENTRY_L2_MV = 12'h064a; // 1610
  localparam logic [11:0] ENTRY_L3_MV = 12'h0730; // 1840
  localparam logic [11:0] LIMIT_L1_MV = 12'h00d2; // 210
  localparam logic [11:0] LIMIT_L2_MV = 12'h0122; // 290
  localparam logic [11:0] LIMIT_L3_MV = 12'h0154; // 340
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    LVL_1 = 2'h1, LVL_2 = 2'h2, LVL_3 = 2'h3
  } bmc_level_e;
  typedef enum logic [4:0] {
    M_NORMAL = 5'h01, M_AR_NORM = 5'h02, M_AR_ODD = 5'h04,
    M_AR_NOSW = 5'h08, M_LATCH = 5'h10
  } bmc_mode_e;
  typedef enum logic [3:0] {
    B_IDLE = 4'h1, B_COUNT = 4'h2, B_SLEEP = 4'h4, B_WAKE = 4'h8
  } bmc_burst_e;
  typedef struct packed {
    logic ref_ok;
    logic vcc_on;
    logic fbk_gt_1v8;
    logic fbk_gt_4v0;
    logic fb_lt_entry;
    logic fbk_gt_3v5;
    logic fbk_lt_3v2;
    logic fbk_gt_4v5;
    logic vcc_ovp;
    logic over_temp;
    logic ext_prot;
    logic latch_clear;
  } bmc_cmp_s;
  localparam int CMP_W = $bits(bmc_cmp_s);
  typedef struct packed {
    logic sense_source_en;
    logic sel_res_connect;
    logic bias_en;
    logic burst_flag;
    logic burst_limit_gate;
    logic switch_en;
    logic fault_detect_en;
    logic soft_start;
    logic latched;
  } bmc_ctl_s;
endpackage : bmc_pkg

//--- src/bmc_core.sv
// burst level select, active burst and restart mode control
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Function
// R01: feedback pin level picks burst level 1, 2 or 3 at 1.8V, 4.0V.
// R02: entry thresholds 1.29V, 1.61V, 1.84V per level.
// R03: reduced burst current limits 0.21V, 0.29V, 0.34V per level.
// R04: low reference-ok clears the level detection latch.
// R05: latch clear and off: resistor off, sense current source on.
// R06: sample level once at turn-on, set latch, hold level afterwards.
// R07: 2us after turn-on, source off and resistor reconnected.
// R08: 20ms blanking below entry threshold enters burst; zero otherwise.
// R09: burst entry sets flag and turns bias off.
// R10: in burst, above 3.5V bias on, switch with reduced limit.
// R11: in burst, at 3.2V bias off again.
// R12: above 4.0V leave burst, restore full current limit.
// R13: odd-skip: odd cycles no detect, no switching; even cycles both.
// R14: odd-skip returns to normal only on fault-free even cycle.
// R15: non-switch: no switching on even cycles either; detect there.
// R16: overvoltage, overload, open loop odd-skip; undervoltage normal restart.
// R17: over temperature non-switch restart; external enable latches.
// R18: every restart attempt runs soft start; code skips it on odd-skip odd cycles and on non-switch cycles.
// R19: overload or open loop held 40ms enters odd-skip.
// R20: external enable held 210us enters latch, switching stops.
// R21: all timers count the one internal clock.
// R22: latch holds until latch clear; other faults ignored.
module bmc_core
  import bmc_pkg::*;
#(
  parameter int BURST_BLANK_CYC = BURST_CYC,
  parameter int OVL_BLANK_CYC   = OVL_CYC
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire bmc_cmp_s    cmp_async,
  output bmc_ctl_s         ctl,
  output logic [11:0]      entry_thresh_mv,
  output logic [11:0]      limit_thresh_mv
);
  // ==========================================================
  // decoders
  function automatic bmc_level_e lvl_dec(input logic gt18,
                                         input logic gt40);
    lvl_dec = gt40 ? LVL_3 : (gt18 ? LVL_2 : LVL_1); // [R01]
  endfunction : lvl_dec

  function automatic logic [23:0] thr_dec(input bmc_level_e l);
    unique case (l)
      LVL_1:   thr_dec = {ENTRY_L1_MV, LIMIT_L1_MV}; // [R02] [R03]
      LVL_2:   thr_dec = {ENTRY_L2_MV, LIMIT_L2_MV}; // [R02] [R03]
      LVL_3:   thr_dec = {ENTRY_L3_MV, LIMIT_L3_MV}; // [R02] [R03]
      default: thr_dec = {ENTRY_L1_MV, LIMIT_L1_MV};
    endcase
  endfunction : thr_dec

  // ==========================================================
  // input synchronisers
  logic [CMP_W-1:0] cmp_v;
  logic [CMP_W-1:0] s1_q;
  logic [CMP_W-1:0] s2_q;
  bmc_cmp_s         cmp;
  assign cmp_v = cmp_async;
  for (genvar i = 0; i < CMP_W; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= cmp_v[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end
  assign cmp = bmc_cmp_s'(s2_q);

  // ==========================================================
  // bus state
  logic        ack_q, ack_d;
  logic        ben_q, ben_d;
  logic        clr_q, clr_d;
  logic [31:0] rdata_q, rdata_d;
  // ==========================================================
  // control state
  logic              det_q, det_d;
  bmc_level_e        lvl_q, lvl_d;
  logic [SEL_W-1:0]  sel_q, sel_d;
  logic              on_q, on_d;
  logic              vprev_q, vprev_d;
  bmc_burst_e        bst_q, bst_d;
  logic [CNT_W-1:0]  blank_q, blank_d;
  logic [CNT_W-1:0]  ovl_q, ovl_d;
  logic [EXT_W-1:0]  ext_q, ext_d;
  bmc_mode_e         mode_q, mode_d;
  logic              odd_q, odd_d;
  bmc_ctl_s          ctl_q, ctl_d;
  logic [23:0]       thr_q, thr_d;
  logic              turn_on, turn_off, burst_ok, ext_hit, ovl_hit;
  logic              fault_en, fault_now, exit_b;

  always_comb begin
    turn_on   = cmp.vcc_on & ~vprev_q;
    turn_off  = ~cmp.vcc_on & vprev_q;
    burst_ok  = (mode_q == M_NORMAL) & on_q;
    exit_b    = cmp.fbk_gt_4v0 | ~burst_ok;
    fault_now = cmp.vcc_ovp | cmp.fbk_gt_4v5 | cmp.over_temp;
    // detection off on odd restart cycles
    fault_en  = (mode_q == M_NORMAL) | (mode_q == M_AR_NORM)
              | (((mode_q == M_AR_ODD) | (mode_q == M_AR_NOSW)) & ~odd_q); // [R13] [R15]
    det_d   = det_q;
    lvl_d   = lvl_q;
    sel_d   = sel_q;
    on_d    = on_q;
    vprev_d = cmp.vcc_on;
    bst_d   = bst_q;
    blank_d = blank_q;
    ovl_d   = '0;
    ext_d   = '0;
    mode_d  = mode_q;
    odd_d   = odd_q;
    // level capture, once per power-up
    if (!cmp.ref_ok) begin
      det_d = 1'b0; // [R04]
    end else if (turn_on && !det_q) begin
      det_d = 1'b1; // [R06]
      lvl_d = lvl_dec(cmp.fbk_gt_1v8, cmp.fbk_gt_4v0); // [R01] [R06]
      sel_d = SEL_W'(SEL_CYC); // [R07] [R21]
    end else if (sel_q != '0) begin
      sel_d = sel_q - 1'b1; // [R07]
    end
    if (turn_on) begin
      on_d = 1'b1;
    end else if (turn_off) begin
      on_d = 1'b0;
    end
    // active burst
    unique case (bst_q)
      B_IDLE: begin
        blank_d = '0; // [R08]
        if (burst_ok && ben_q && cmp.fb_lt_entry) begin
          bst_d = B_COUNT;
        end
      end
      B_COUNT: begin
        if (!burst_ok || !cmp.fb_lt_entry) begin
          bst_d   = B_IDLE;
          blank_d = '0;
        end else if (blank_q == CNT_W'(BURST_BLANK_CYC - 1)) begin
          bst_d = B_SLEEP; // [R08] [R09]
        end else begin
          blank_d = blank_q + 1'b1; // [R21]
        end
      end
      B_SLEEP: begin
        if (exit_b) begin
          bst_d = B_IDLE; // [R12]
        end else if (cmp.fbk_gt_3v5) begin
          bst_d = B_WAKE; // [R10]
        end
      end
      B_WAKE: begin
        if (exit_b) begin
          bst_d = B_IDLE; // [R12]
        end else if (cmp.fbk_lt_3v2) begin
          bst_d = B_SLEEP; // [R11]
        end
      end
    endcase
    // blanking of overload and external enable
    ovl_hit = 1'b0;
    ext_hit = 1'b0;
    if (fault_en && on_q && cmp.fbk_gt_4v5) begin
      ovl_hit = ovl_q == CNT_W'(OVL_BLANK_CYC - 1); // [R19]
      ovl_d   = ovl_hit ? '0 : ovl_q + 1'b1; // [R21]
    end
    if (mode_q != M_LATCH && cmp.ext_prot) begin
      ext_hit = ext_q == EXT_W'(EXT_CYC - 1); // [R20]
      ext_d   = ext_hit ? '0 : ext_q + 1'b1; // [R21]
    end
    // protection modes; latch first, then the milder classes
    unique case (mode_q)
      M_NORMAL: begin
        odd_d = 1'b0;
        if (ext_hit) begin
          mode_d = M_LATCH; // [R17] [R20]
        end else if (on_q && cmp.over_temp) begin
          mode_d = M_AR_NOSW; // [R17]
        end else if (on_q && (cmp.vcc_ovp || ovl_hit)) begin
          mode_d = M_AR_ODD; // [R16] [R19]
        end else if (on_q && turn_off) begin
          mode_d = M_AR_NORM; // [R16]
        end
      end
      M_AR_NORM: begin
        if (ext_hit) begin
          mode_d = M_LATCH; // [R17]
        end else if (turn_on) begin
          mode_d = M_NORMAL; // [R18]
        end
      end
      M_AR_ODD, M_AR_NOSW: begin
        if (ext_hit) begin
          mode_d = M_LATCH; // [R17]
        end else if (turn_on) begin
          odd_d = ~odd_q;
          if (odd_q && !fault_now) begin
            mode_d = M_NORMAL; // [R14] [R15]
          end
        end
      end
      M_LATCH: begin
        odd_d = 1'b0;
        if (cmp.latch_clear || clr_q) begin
          mode_d = M_NORMAL; // [R22]
        end
      end
    endcase
    // outputs, registered
    ctl_d.sense_source_en  = (~det_q & ~on_q) | (sel_q != '0); // [R05] [R07]
    ctl_d.sel_res_connect  = ~ctl_d.sense_source_en; // [R05] [R07]
    ctl_d.burst_flag       = (bst_q == B_SLEEP) | (bst_q == B_WAKE); // [R09]
    ctl_d.burst_limit_gate = ctl_d.burst_flag; // [R10] [R12]
    ctl_d.bias_en          = on_q & (bst_q != B_SLEEP); // [R09] [R11]
    ctl_d.switch_en        = on_q & (bst_q != B_SLEEP)
                           & ((mode_q == M_NORMAL) | (mode_q == M_AR_NORM)
                           | ((mode_q == M_AR_ODD) & ~odd_q)); // [R13] [R15] [R20]
    ctl_d.fault_detect_en  = fault_en; // [R13]
    ctl_d.soft_start       = turn_on & ((mode_d == M_NORMAL)
                           | (mode_d == M_AR_NORM)
                           | ((mode_d == M_AR_ODD) & ~odd_d)); // [R18]
    ctl_d.latched          = mode_q == M_LATCH; // [R20]
    thr_d = thr_dec(lvl_q); // [R02] [R03]
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      det_q   <= 1'b0;
      lvl_q   <= LVL_1;
      sel_q   <= '0;
      on_q    <= 1'b0;
      vprev_q <= 1'b0;
      bst_q   <= B_IDLE;
      blank_q <= '0;
      ovl_q   <= '0;
      ext_q   <= '0;
      mode_q  <= M_NORMAL;
      odd_q   <= 1'b0;
      ctl_q   <= '0;
      thr_q   <= {ENTRY_L1_MV, LIMIT_L1_MV};
    end else begin
      det_q   <= det_d;
      lvl_q   <= lvl_d;
      sel_q   <= sel_d;
      on_q    <= on_d;
      vprev_q <= vprev_d;
      bst_q   <= bst_d;
      blank_q <= blank_d;
      ovl_q   <= ovl_d;
      ext_q   <= ext_d;
      mode_q  <= mode_d;
      odd_q   <= odd_d;
      ctl_q   <= ctl_d;
      thr_q   <= thr_d;
    end
  end

  assign ctl             = ctl_q;
  assign entry_thresh_mv = thr_q[23:12];
  assign limit_thresh_mv = thr_q[11:0];

  // ==========================================================
  // avalon slave: one wait cycle, read data loaded beforehand
  logic req;
  always_comb begin
    req     = read | write;
    ack_d   = req & ~ack_q;
    ben_d   = ben_q;
    clr_d   = 1'b0;
    rdata_d = rdata_q;
    if (write && ack_q && address == ADDR_CTRL && byteenable[0]) begin
      ben_d = writedata[CTRL_BURST_EN];
      clr_d = writedata[CTRL_LATCH_CLR]; // [R22]
    end
    if (read && !ack_q) begin
      rdata_d = '0;
      unique case (address)
        ADDR_CTRL: rdata_d[CTRL_BURST_EN] = ben_q;
        ADDR_STATUS: begin
          rdata_d[ST_LEVEL+:2] = lvl_q;
          rdata_d[ST_DET]      = det_q;
          rdata_d[ST_FLAG]     = ctl_q.burst_flag;
          rdata_d[ST_BIAS]     = ctl_q.bias_en;
          rdata_d[ST_ODD]      = odd_q;
          rdata_d[ST_MODE+:5]  = mode_q;
        end
        ADDR_THRESH: begin
          rdata_d[11:0]          = thr_q[23:12];
          rdata_d[TH_LIMIT+:12]  = thr_q[11:0];
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ack_q   <= 1'b0;
      ben_q   <= CTRL_BURST_EN_RST;
      clr_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q   <= ack_d;
      ben_q   <= ben_d;
      clr_q   <= clr_d;
      rdata_q <= rdata_d;
    end
  end

  assign waitrequest = req & ~ack_q;
  assign readdata    = rdata_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_capture;
    turn_on && !det_q && cmp.ref_ok;
  endsequence

  a_level_hold: assert property (det_q && cmp.ref_ok |=> lvl_q == $past(lvl_q)) // [R06]
    else $error("burst level changed while latched");
  a_sense_timer: assert property (s_capture |-> ##22 !ctl_q.sense_source_en && ctl_q.sel_res_connect) // [R07]
    else $error("sense source still on after select timer");
  a_refok_clear: assert property (!cmp.ref_ok |=> !det_q) // [R04]
    else $error("detection latch not cleared");
  a_sleep_bias: assert property (bst_q == B_SLEEP |=> !ctl_q.bias_en && ctl_q.burst_flag) // [R09]
    else $error("bias on during burst sleep");
  a_burst_wake: assert property (bst_q == B_SLEEP && cmp.fbk_gt_3v5 && !exit_b |=> bst_q == B_WAKE) // [R10]
    else $error("no wake above upper level");
  a_burst_resleep: assert property (bst_q == B_WAKE && cmp.fbk_lt_3v2 && !exit_b |=> bst_q == B_SLEEP) // [R11]
    else $error("no sleep at lower level");
  a_burst_exit: assert property (ctl_d.burst_flag && cmp.fbk_gt_4v0 |=> bst_q == B_IDLE ##1 !ctl_q.burst_limit_gate) // [R12]
    else $error("reduced limit kept after exit");
  a_latch_hold: assert property (mode_q == M_LATCH && !cmp.latch_clear && !clr_q |=> mode_q == M_LATCH) // [R22]
    else $error("latch left without clear");
  a_odd_skip: assert property ((mode_q == M_AR_ODD && odd_q)[*2] |-> !ctl_q.switch_en && !ctl_q.fault_detect_en) // [R13]
    else $error("switching on odd restart cycle");
  a_nosw_quiet: assert property ((mode_q == M_AR_NOSW)[*2] |-> !ctl_q.switch_en) // [R15]
    else $error("switching in non-switch restart");
endmodule : bmc_core

//--- testbench/bmc_plant.sv
// comparator and supply model on the far side of the mode control block
`timescale 1ns/10ps
module bmc_plant
  import bmc_pkg::*;
(
  input  wire logic [15:0] vcc_mv,
  input  wire logic [15:0] fbk_mv,
  input  wire logic [11:0] entry_mv,
  input  wire logic        hot,
  input  wire logic        ext_en,
  input  wire logic        clr,
  output bmc_cmp_s         cmp
);
  // ==========================================================
  // supply lockout: on at 17V, off below 10.5V; hysteresis keeps it steady in between
  logic on_q = 1'b0;
  always @(vcc_mv) begin
    if (vcc_mv >= 16'h4268) on_q = 1'b1;
    else if (vcc_mv < 16'h2904) on_q = 1'b0;
  end
  // ==========================================================
  // comparators, levels in millivolts
  always_comb begin
    cmp             = '0;
    cmp.ref_ok      = vcc_mv >= 16'h1f40;
    cmp.vcc_on      = on_q;
    cmp.fbk_gt_1v8  = fbk_mv > 16'h0708;
    cmp.fbk_gt_4v0  = fbk_mv > 16'h0fa0;
    cmp.fb_lt_entry = fbk_mv < {4'h0, entry_mv};
    cmp.fbk_gt_3v5  = fbk_mv > 16'h0dac;
    cmp.fbk_lt_3v2  = fbk_mv <= 16'h0c80;
    cmp.fbk_gt_4v5  = fbk_mv > 16'h1194;
    cmp.vcc_ovp     = vcc_mv > 16'h639c;
    cmp.over_temp   = hot;
    cmp.ext_prot    = ext_en;
    cmp.latch_clear = clr;
  end
endmodule : bmc_plant

//--- testbench/burst_and_restart_mode_control_tb_top.sv
// self-checking bench for the burst and restart mode control
`timescale 1ns/10ps
module burst_and_restart_mode_control_tb_top;
  import bmc_pkg::*;
  typedef struct packed {logic [15:0] fbk; logic [1:0] lvl; logic [11:0] ent; logic [11:0] lim;} bmc_row_s;
  logic        mclk, resetn, read, write, waitrequest, hot, ext_en, clr;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [15:0] vcc_mv, fbk_mv;
  logic [11:0] entry_thresh_mv, limit_thresh_mv;
  bmc_cmp_s    cmp;
  bmc_ctl_s    ctl;
  int          errors, samples_checked, k;
  int          ss_cnt = 0;
  bmc_row_s    rows [3];

  bmc_core #(.BURST_BLANK_CYC(50), .OVL_BLANK_CYC(80)) i_dut (.mclk(mclk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'h1),
    .readdata(readdata), .waitrequest(waitrequest), .cmp_async(cmp), .ctl(ctl),
    .entry_thresh_mv(entry_thresh_mv), .limit_thresh_mv(limit_thresh_mv));
  bmc_plant i_plant (.vcc_mv(vcc_mv), .fbk_mv(fbk_mv), .entry_mv(entry_thresh_mv), .hot(hot),
    .ext_en(ext_en), .clr(clr), .cmp(cmp));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // soft start is a one-cycle pulse, so it is counted rather than sampled
  always @(posedge mclk) if (ctl.soft_start === 1'b1) ss_cnt <= ss_cnt + 1;

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic go(input int n);
    repeat (n) @(posedge mclk);
  endtask : go
  // request stands until waitrequest is seen low at a rising edge; pre-edge values are read there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    address   <= a;
    read      <= ~wr;
    write     <= wr;
    writedata <= wd;
    @(posedge mclk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      errors++;
      stop_test;
    end
  endtask : bus
  task automatic mode(input logic [4:0] m);
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("mode", {27'h0, rd[12:8]}, {27'h0, m});
  endtask : mode
  task automatic set_v(input logic [15:0] v, input logic [15:0] f);
    @(posedge mclk);
    vcc_mv <= v;
    fbk_mv <= f;
  endtask : set_v
  task automatic restart(input logic [15:0] f);
    set_v(16'h2328, f);
    go(8);
    set_v(16'h445c, f);
    go(8);
    @(negedge mclk);
  endtask : restart

  // ==========================================================
  // main sequence
  initial begin
    resetn = 1'b0; read = 1'b0; write = 1'b0; address = 4'h0; writedata = 32'h0000_0000;
    hot = 1'b0; ext_en = 1'b0; clr = 1'b0; vcc_mv = 16'h0000; fbk_mv = 16'h09c4;
    errors = 0; samples_checked = 0;
    rows[0] = {16'h03e8, 2'h1, ENTRY_L1_MV, LIMIT_L1_MV};
    rows[1] = {16'h0bb8, 2'h2, ENTRY_L2_MV, LIMIT_L2_MV};
    rows[2] = {16'h1068, 2'h3, ENTRY_L3_MV, LIMIT_L3_MV};
    go(4);
    resetn <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0001);
    bus(1'b0, ADDR_THRESH, 32'h0000_0000);
    chk("thresh", rd, {4'h0, LIMIT_L1_MV, 4'h0, ENTRY_L1_MV});
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    foreach (rows[i]) begin
      set_v(16'h0000, rows[i].fbk);
      go(6);
      @(negedge mclk);
      chk("sense", ctl.sense_source_en, 1'b1);
      set_v(16'h2ee0, rows[i].fbk);
      go(5);
      set_v(16'h445c, rows[i].fbk);
      go(10);
      @(negedge mclk);
      chk("sense_hold", ctl.sense_source_en, 1'b1);
      go(25);
      @(negedge mclk);
      chk("sense_off", {ctl.sense_source_en, ctl.sel_res_connect}, 2'b01);
      chk("entry", entry_thresh_mv, rows[i].ent);
      chk("limit", limit_thresh_mv, rows[i].lim);
      bus(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk("level", rd[1:0], rows[i].lvl);
      set_v(16'h445c, 16'h09c4);
      go(6);
      @(negedge mclk);
      chk("entry_kept", entry_thresh_mv, rows[i].ent);
    end
    set_v(16'h445c, 16'h05dc);
    go(30);
    set_v(16'h445c, 16'h09c4);
    go(5);
    @(negedge mclk);
    chk("short_dip", ctl.burst_flag, 1'b0);
    set_v(16'h445c, 16'h05dc);
    go(62);
    @(negedge mclk);
    chk("burst", {ctl.burst_flag, ctl.bias_en}, 2'b10);
    set_v(16'h445c, 16'h0e10);
    go(6);
    @(negedge mclk);
    chk("wake", {ctl.bias_en, ctl.burst_limit_gate, ctl.switch_en}, 3'b111);
    set_v(16'h445c, 16'h0ce4);
    go(6);
    @(negedge mclk);
    chk("band", ctl.bias_en, 1'b1);
    set_v(16'h445c, 16'h0c1c);
    go(6);
    @(negedge mclk);
    chk("sleep", ctl.bias_en, 1'b0);
    set_v(16'h445c, 16'h1068);
    go(6);
    @(negedge mclk);
    chk("exit", {ctl.burst_flag, ctl.burst_limit_gate}, 2'b00);
    bus(1'b1, ADDR_CTRL, 32'h0000_0000);
    set_v(16'h445c, 16'h05dc);
    go(62);
    @(negedge mclk);
    chk("burst_off", ctl.burst_flag, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0000_0001);
    set_v(16'h445c, 16'h125c);
    go(90);
    mode(M_AR_ODD);
    restart(16'h125c);
    chk("odd", {ctl.switch_en, ctl.fault_detect_en}, 2'b00);
    restart(16'h125c);
    chk("even", ctl.switch_en, 1'b1);
    mode(M_AR_ODD);
    restart(16'h09c4);
    k = ss_cnt;
    restart(16'h09c4);
    mode(M_NORMAL);
    chk("soft", ss_cnt - k, 32'h0000_0001);
    set_v(16'h2328, 16'h09c4);
    go(8);
    mode(M_AR_NORM);
    set_v(16'h6590, 16'h09c4);
    go(8);
    mode(M_AR_ODD);
    restart(16'h09c4);
    restart(16'h09c4);
    @(posedge mclk);
    hot <= 1'b1;
    go(8);
    mode(M_AR_NOSW);
    restart(16'h09c4);
    restart(16'h09c4);
    chk("nosw", {ctl.switch_en, ctl.fault_detect_en}, 2'b01);
    @(posedge mclk);
    hot <= 1'b0;
    restart(16'h09c4);
    restart(16'h09c4);
    mode(M_NORMAL);
    // a pulse just short of the blanking time must not latch
    @(posedge mclk);
    ext_en <= 1'b1;
    go(2000);
    ext_en <= 1'b0;
    go(8);
    mode(M_NORMAL);
    ext_en <= 1'b1;
    go(2110);
    @(negedge mclk);
    chk("latch", {ctl.latched, ctl.switch_en}, 2'b10);
    @(posedge mclk);
    hot <= 1'b1;
    go(8);
    mode(M_LATCH);
    hot <= 1'b0;
    ext_en <= 1'b0;
    go(8);
    mode(M_LATCH);
    bus(1'b1, ADDR_CTRL, 32'h0000_0003);
    go(8);
    mode(M_NORMAL);
    // the clear pin must end the latch as the register bit does
    ext_en <= 1'b1;
    go(2110);
    mode(M_LATCH);
    ext_en <= 1'b0;
    clr <= 1'b1;
    go(8);
    clr <= 1'b0;
    mode(M_NORMAL);
    stop_test;
  end
endmodule : burst_and_restart_mode_control_tb_top
